// ===== verilog/spcr_pkg.sv
// package: constants for the serial port configuration register block
package spcr_pkg;
  // register offsets
  localparam logic [12:0] OFS_PORT_SETUP  = 13'h0000;
  localparam logic [12:0] OFS_PART_ID     = 13'h0001;
  localparam logic [12:0] OFS_SPEED_GRADE = 13'h0002;
  // port setup register layout
  localparam logic [7:0]  SETUP_RESET     = 8'h18;
  localparam logic [7:0]  SETUP_FIXED_ONE = 8'h18;
  localparam int          BIT_LSB_HI      = 6;
  localparam int          BIT_LSB_LO      = 1;
  localparam int          BIT_SRST_HI     = 5;
  localparam int          BIT_SRST_LO     = 2;
  // speed grade register layout
  localparam logic [7:0]  GRADE_RESET     = 8'h00;
  localparam int          GRADE_LSB       = 4;
  localparam logic [7:0]  GRADE_MASK      = 8'h30;
  localparam logic [7:0]  UNMAPPED_READ   = 8'h00;
  // instruction word layout
  localparam int          INSTR_BITS      = 16;
  localparam int          INSTR_RD_BIT    = 15;
  localparam int          INSTR_W_LSB     = 13;
  localparam logic [3:0]  INSTR_LAST      = 4'hF;
  localparam logic [2:0]  BYTE_LAST       = 3'h7;
  localparam logic [1:0]  W_STREAM        = 2'h3;
  // frame phases
  typedef enum logic [1:0] {
    SPCR_PH_INSTR = 2'b00,
    SPCR_PH_DATA  = 2'b01,
    SPCR_PH_DONE  = 2'b10
  } spcr_phase_t;
endpackage : spcr_pkg

// ===== verilog/spcr_regs.sv
// register bank: port setup, part identity and speed grade registers
`timescale 1ns/1ps
`default_nettype none
module spcr_regs #(
  parameter logic [7:0] PART_ID    = 8'hA5,  // arbitrary value
  parameter logic [1:0] GRADE_CODE = 2'h0
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        wr_en,
  input  wire logic [12:0] wr_addr,
  input  wire logic [7:0]  wr_data,
  input  wire logic [12:0] rd_addr,
  output logic      [7:0]  rd_data_q,
  output logic             lsb_first_q,
  output logic             soft_rst_q
);

  logic [1:0] lsb_bits_q;  // stored copies at the two mirrored positions
  logic [7:0] setup_view;
  logic [7:0] grade_view;
  logic       wr_setup;
  logic       srst_req;

  assign wr_setup = wr_en && (wr_addr == spcr_pkg::OFS_PORT_SETUP);
  assign srst_req = wr_data[spcr_pkg::BIT_SRST_HI] | wr_data[spcr_pkg::BIT_SRST_LO];

  // setup register: fixed ones, mirrored bit order, soft bits read as zero
  assign setup_view = spcr_pkg::SETUP_FIXED_ONE
                    | ({7'h00, lsb_bits_q[1]} << spcr_pkg::BIT_LSB_HI)
                    | ({7'h00, lsb_bits_q[0]} << spcr_pkg::BIT_LSB_LO);
  // grade register: only the code field is defined
  assign grade_view = spcr_pkg::GRADE_MASK
                    & ({6'h00, GRADE_CODE} << spcr_pkg::GRADE_LSB);

  //////////////////////////////////////////////////////////////////////////
  // port setup storage, takes effect on the write itself
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lsb_bits_q <= 2'h0;
    end else if (wr_setup && srst_req) begin
      lsb_bits_q <= 2'h0;
    end else if (wr_setup) begin
      lsb_bits_q <= {wr_data[spcr_pkg::BIT_LSB_HI],
                     wr_data[spcr_pkg::BIT_LSB_LO]};
    end
  end

  // decoded controls: either mirrored copy selects lsb first
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lsb_first_q <= 1'b0;
      soft_rst_q  <= 1'b0;
    end else begin
      lsb_first_q <= (wr_setup && !srst_req)
                     ? (wr_data[spcr_pkg::BIT_LSB_HI] | wr_data[spcr_pkg::BIT_LSB_LO])
                     : ((wr_setup && srst_req) ? 1'b0 : (|lsb_bits_q));
      soft_rst_q  <= wr_setup && srst_req;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // registered read mux; writes to read-only locations are ignored
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_data_q <= spcr_pkg::SETUP_RESET;
    end else if (rd_addr == spcr_pkg::OFS_PORT_SETUP) begin
      rd_data_q <= setup_view;
    end else if (rd_addr == spcr_pkg::OFS_PART_ID) begin
      rd_data_q <= PART_ID;
    end else if (rd_addr == spcr_pkg::OFS_SPEED_GRADE) begin
      rd_data_q <= grade_view;
    end else begin
      rd_data_q <= spcr_pkg::UNMAPPED_READ;
    end
  end

endmodule : spcr_regs
`default_nettype wire

// ===== verilog/spcr_top.sv
// serial control port frame engine with the chip configuration registers
`timescale 1ns/1ps
`default_nettype none
module spcr_top #(
  parameter logic [7:0] PART_ID    = 8'hA5,  // arbitrary value
  parameter logic [1:0] GRADE_CODE = 2'h0
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic sclk,
  input  wire logic csb_n,
  input  wire logic sdio_in,
  output logic      sdio_out,
  output logic      sdio_oe,
  output logic      lsb_first,
  output logic      soft_reset
);

  logic                 sclk_q;
  logic                 sclk_rise;
  logic                 sclk_fall;
  spcr_pkg::spcr_phase_t phase_q;
  logic [3:0]           bit_cnt_q;
  logic [1:0]           byte_cnt_q;
  logic [15:0]          shift_q;
  logic [15:0]          shift_d;
  logic [12:0]          addr_q;
  logic                 rd_q;
  logic [1:0]           wlen_q;
  logic [7:0]           tx_q;
  logic                 wr_en_q;
  logic [12:0]          wr_addr_q;
  logic [7:0]           wr_data_q;
  logic [7:0]           rd_data;
  logic                 lsb_q;
  logic                 srst_q;
  logic                 instr_end;
  logic                 byte_end;

  //////////////////////////////////////////////////////////////////////////
  // serial clock edges, pins are synchronous to clk
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= sclk;
    end
  end
  assign sclk_rise = sclk & ~sclk_q & ~csb_n;
  assign sclk_fall = ~sclk & sclk_q & ~csb_n;

  // input shift: msb first shifts left, lsb first shifts right
  assign shift_d = lsb_q ? {sdio_in, shift_q[15:1]}
                         : {shift_q[14:0], sdio_in};

  // frame milestones: a frame is sixteen instruction bits, then data bytes;
  // these mark the last instruction bit and the last bit of each data byte
  assign instr_end = sclk_rise && phase_q == spcr_pkg::SPCR_PH_INSTR
                     && bit_cnt_q == spcr_pkg::INSTR_LAST;
  assign byte_end  = sclk_rise && phase_q == spcr_pkg::SPCR_PH_DATA
                     && bit_cnt_q[2:0] == spcr_pkg::BYTE_LAST;

  //////////////////////////////////////////////////////////////////////////
  // input shift register; chip select high drops a partial byte
  always_ff @(posedge clk) begin
    if (sys_rst || csb_n) begin
      shift_q <= 16'h0000;
    end else if (sclk_rise) begin
      shift_q <= shift_d;
    end
  end

  // bit counter: sixteen instruction bits, then eight per data byte
  always_ff @(posedge clk) begin
    if (sys_rst || csb_n || instr_end) begin
      bit_cnt_q <= 4'h0;
    end else if (sclk_rise && phase_q == spcr_pkg::SPCR_PH_INSTR) begin
      bit_cnt_q <= bit_cnt_q + 4'h1;
    end else if (sclk_rise && phase_q == spcr_pkg::SPCR_PH_DATA) begin
      bit_cnt_q <= {1'b0, bit_cnt_q[2:0] + 3'h1};         // wraps every byte
    end
  end

  // byte counter within the data phase
  always_ff @(posedge clk) begin
    if (sys_rst || csb_n || instr_end) begin
      byte_cnt_q <= 2'h0;
    end else if (byte_end) begin
      byte_cnt_q <= byte_cnt_q + 2'h1;
    end
  end

  // frame phase; chip select high aborts and waits for an instruction,
  // a finished non-streaming frame ignores bytes until deselect
  always_ff @(posedge clk) begin
    if (sys_rst || csb_n) begin
      phase_q <= spcr_pkg::SPCR_PH_INSTR;
    end else if (sclk_rise) begin
      case (phase_q)
        spcr_pkg::SPCR_PH_INSTR: begin
          if (instr_end) begin
            phase_q <= spcr_pkg::SPCR_PH_DATA;
          end
        end
        spcr_pkg::SPCR_PH_DATA: begin
          if (byte_end && wlen_q != spcr_pkg::W_STREAM && byte_cnt_q == wlen_q) begin
            phase_q <= spcr_pkg::SPCR_PH_DONE;
          end
        end
        default: begin
          phase_q <= spcr_pkg::SPCR_PH_DONE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // instruction decode: direction and word length
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_q   <= 1'b0;
      wlen_q <= 2'h0;
    end else if (instr_end) begin
      rd_q   <= shift_d[spcr_pkg::INSTR_RD_BIT];
      wlen_q <= shift_d[spcr_pkg::INSTR_W_LSB +: 2];
    end
  end

  // register address: loaded from the instruction, stepped after each byte
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      addr_q <= 13'h0000;
    end else if (instr_end) begin
      addr_q <= shift_d[12:0];
    end else if (byte_end) begin
      addr_q <= lsb_q ? addr_q + 13'h0001 : addr_q - 13'h0001;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // write strobe to the register bank once a whole byte is in
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_en_q   <= 1'b0;
      wr_addr_q <= 13'h0000;
      wr_data_q <= 8'h00;
    end else begin
      wr_en_q   <= byte_end && !rd_q;
      wr_addr_q <= addr_q;
      wr_data_q <= lsb_q ? shift_d[15:8] : shift_d[7:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // data line enable: on from the first falling edge of read data
  always_ff @(posedge clk) begin
    if (sys_rst || csb_n) begin
      sdio_oe <= 1'b0;
    end else if (phase_q != spcr_pkg::SPCR_PH_DATA || !rd_q) begin
      sdio_oe <= 1'b0;
    end else if (sclk_fall && bit_cnt_q == 4'h0) begin
      sdio_oe <= 1'b1;
    end
  end

  // read data: load each byte on its first falling edge, then shift
  always_ff @(posedge clk) begin
    if (sys_rst || csb_n) begin
      sdio_out <= 1'b0;
      tx_q     <= 8'h00;
    end else if (phase_q == spcr_pkg::SPCR_PH_DATA && rd_q && sclk_fall) begin
      if (bit_cnt_q == 4'h0) begin
        sdio_out <= lsb_q ? rd_data[0] : rd_data[7];
        tx_q     <= lsb_q ? {1'b0, rd_data[7:1]} : {rd_data[6:0], 1'b0};
      end else begin
        sdio_out <= lsb_q ? tx_q[0] : tx_q[7];
        tx_q     <= lsb_q ? {1'b0, tx_q[7:1]} : {tx_q[6:0], 1'b0};
      end
    end
  end

  // register bank
  spcr_regs #(
    .PART_ID    (PART_ID),
    .GRADE_CODE (GRADE_CODE)
  ) u_regs (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .wr_en       (wr_en_q),
    .wr_addr     (wr_addr_q),
    .wr_data     (wr_data_q),
    .rd_addr     (addr_q),
    .rd_data_q   (rd_data),
    .lsb_first_q (lsb_q),
    .soft_rst_q  (srst_q)
  );

  // status copies for the rest of the chip
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lsb_first  <= 1'b0;
      soft_reset <= 1'b0;
    end else begin
      lsb_first  <= lsb_q;
      soft_reset <= srst_q;
    end
  end

endmodule : spcr_top
`default_nettype wire

// ===== testbench/spcr_monitor.sv
// checker: port-level properties of the serial config block
`timescale 1ns/1ps
`default_nettype none
module spcr_monitor (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sclk,
  input wire logic csb_n,
  input wire logic sdio_in,
  input wire logic sdio_out,
  input wire logic sdio_oe,
  input wire logic lsb_first,
  input wire logic soft_reset
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////////////
  // outputs tied to their causes at the pins
  rst_quiet_a: assert property ($fell(sys_rst) |-> !sdio_oe && !lsb_first && !soft_reset)
    else $error("outputs not cleared by reset");
  srst_pulse_a: assert property (soft_reset |=> !soft_reset)
    else $error("soft reset pulse too long");
  srst_order_a: assert property (soft_reset |-> ##[0:2] !lsb_first)
    else $error("bit order kept over soft reset");
  oe_start_a: assert property ($rose(sdio_oe) |-> !$past(sclk) && $past(sclk, 2))
    else $error("drive began off a falling serial edge");
  out_shift_a: assert property (sdio_oe && $past(sdio_oe) && $changed(sdio_out)
    |-> !$past(sclk) && $past(sclk, 2))
    else $error("read bit moved off a falling serial edge");
  oe_select_a: assert property (sdio_oe |-> !$past(csb_n))
    else $error("drive without chip select");
  oe_release_a: assert property (csb_n [*3] |-> !sdio_oe)
    else $error("drive kept after deselect");
  order_late_a: assert property ($rose(lsb_first) |-> !$past(csb_n, 4))
    else $error("bit order changed outside a write");
  order_idle_a: assert property (csb_n [*8] |=> $stable(lsb_first))
    else $error("bit order moved while idle");
endmodule : spcr_monitor
bind spcr_top spcr_monitor u_spcr_monitor (.clk(clk), .sys_rst(sys_rst), .sclk(sclk),
  .csb_n(csb_n), .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
  .lsb_first(lsb_first), .soft_reset(soft_reset));
`default_nettype wire

// ===== testbench/spcr_host.sv
// serial host model: frames of nb data bytes on the control port
`timescale 1ns/1ps
`default_nettype none
module spcr_host (
  input  wire logic clk,
  input  wire logic sdio,
  output logic      sclk,
  output logic      csb_n,
  output logic      host_d
);
  // idle: deselected, serial clock parked low
  initial begin
    sclk = 1'b0;
    csb_n = 1'b1;
    host_d = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // frame: instruction then nb bytes, in the order the caller selects
  // the first byte sits in the upper byte of wd and rd when nb is two
  task automatic xfer(input logic [15:0] ins, input logic [15:0] wd, input logic lsb,
                      input int nb, output logic [15:0] rd);
    int t;
    int idx;
    rd = 16'h0000;
    csb_n = 1'b0;
    for (int i = 8 * nb + 15; i >= 0; i--) begin
      t = 8 * nb + 15 - i;
      idx = (t < 16) ? (lsb ? t : 15 - t)
                     : 8 * (nb - 1 - (t - 16) / 8) + (lsb ? (t - 16) % 8 : 7 - (t - 16) % 8);
      sclk = 1'b0;
      host_d = (t < 16) ? ins[idx] : (ins[15] ? ~host_d : wd[idx]); // released line toggles
      repeat (4) @(negedge clk);
      sclk = 1'b1;
      if (t >= 16) rd[idx] = sdio;
      repeat (4) @(negedge clk);
    end
    sclk = 1'b0;
    repeat (8) @(negedge clk);
    csb_n = 1'b1;
    repeat (8) @(negedge clk);
  endtask : xfer
endmodule : spcr_host
`default_nettype wire

// ===== testbench/testbench.sv
// testbench: register map scenarios through the serial control port
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [7:0] PART_ID = 8'h3C; // arbitrary value
  logic       clk;
  logic       sys_rst;
  logic       sclk;
  logic       csb_n;
  logic       host_d;
  logic       sdio_out;
  logic       sdio_oe;
  logic       lsb_first;
  logic       soft_reset;
  wire logic  sdio_w;
  int         num_errors = 0;
  int         cmp_count = 0;
  int         srst_cnt = 0;
  logic [7:0] rd;
  logic [15:0] rd2;
  // shared data line: the device wins while it drives
  assign sdio_w = sdio_oe ? sdio_out : host_d;
  spcr_top #(.PART_ID(PART_ID), .GRADE_CODE(2'h0)) u_spcr_top (.clk(clk), .sys_rst(sys_rst),
    .sclk(sclk), .csb_n(csb_n), .sdio_in(sdio_w), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
    .lsb_first(lsb_first), .soft_reset(soft_reset));
  spcr_host u_spcr_host (.clk(clk), .sdio(sdio_w), .sclk(sclk), .csb_n(csb_n), .host_d(host_d));
  ////////////////////////////////////////////////////////////////////////////
  // clock and soft reset pulse counter
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    if (soft_reset === 1'b1) srst_cnt <= srst_cnt + 1;
  end
  ////////////////////////////////////////////////////////////////////////////
  // compare, register access and verdict
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check8
  task automatic rw(input logic r, input logic [12:0] a, input logic [7:0] d, input logic m);
    u_spcr_host.xfer({r, 2'b00, a}, {8'h00, d}, m, 1, rd2);
    rd = rd2[7:0];
  endtask : rw
  task automatic close_out();
    $display("errors=%0d compares=%0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out
  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_defaults();
    rw(1'b1, spcr_pkg::OFS_PORT_SETUP, 8'h00, 1'b0);
    check8(rd, 8'h18);
    rw(1'b1, spcr_pkg::OFS_SPEED_GRADE, 8'h00, 1'b0);
    check8(rd, 8'h00);
    rw(1'b1, spcr_pkg::OFS_PART_ID, 8'h00, 1'b0);
    check8(rd, PART_ID);
    check8({7'h00, lsb_first}, 8'h00);
  endtask : t_defaults
  task automatic t_read_only();
    rw(1'b0, spcr_pkg::OFS_PART_ID, ~PART_ID, 1'b0);
    rw(1'b1, spcr_pkg::OFS_PART_ID, 8'h00, 1'b0);
    check8(rd, PART_ID);
    rw(1'b0, spcr_pkg::OFS_SPEED_GRADE, 8'h30, 1'b0);
    rw(1'b1, spcr_pkg::OFS_SPEED_GRADE, 8'h00, 1'b0);
    check8(rd, 8'h00);
    rw(1'b1, 13'h0003, 8'h00, 1'b0);
    check8(rd, spcr_pkg::UNMAPPED_READ);
  endtask : t_read_only
  task automatic t_lsb_mode();
    rw(1'b0, spcr_pkg::OFS_PORT_SETUP, 8'h5A, 1'b0);
    check8({7'h00, lsb_first}, 8'h01);
    rw(1'b1, spcr_pkg::OFS_PORT_SETUP, 8'h00, 1'b1);
    check8(rd, 8'h5A);
    rw(1'b1, spcr_pkg::OFS_PART_ID, 8'h00, 1'b1);
    check8(rd, PART_ID);
  endtask : t_lsb_mode
  task automatic t_soft_reset();
    rw(1'b0, spcr_pkg::OFS_PORT_SETUP, 8'h7E, 1'b1);
    check8(8'(srst_cnt), 8'h01);
    check8({7'h00, lsb_first}, 8'h00);
    rw(1'b1, spcr_pkg::OFS_PORT_SETUP, 8'h00, 1'b0);
    check8(rd, 8'h18);
  endtask : t_soft_reset
  // two-byte read stepping down, then a streamed read stepping up
  task automatic t_multi_byte();
    u_spcr_host.xfer({1'b1, 2'b01, spcr_pkg::OFS_PART_ID}, 16'h0000, 1'b0, 2, rd2);
    check8(rd2[15:8], PART_ID);
    check8(rd2[7:0], 8'h18);
    rw(1'b0, spcr_pkg::OFS_PORT_SETUP, 8'h5A, 1'b0);
    u_spcr_host.xfer({1'b1, 2'b11, spcr_pkg::OFS_PART_ID}, 16'h0000, 1'b1, 2, rd2);
    check8(rd2[15:8], PART_ID);
    check8(rd2[7:0], 8'h00);
  endtask : t_multi_byte
  ////////////////////////////////////////////////////////////////////////////
  // main sequence and watchdog
  initial begin
    sys_rst = 1'b1;
    repeat (20) @(negedge clk);
    sys_rst = 1'b0;
    t_defaults();
    t_read_only();
    t_lsb_mode();
    t_soft_reset();
    t_multi_byte();
    close_out();
  end
  initial begin
    #500000;
    num_errors++;
    close_out();
  end
endmodule : testbench
`default_nettype wire
